// *** rtl/four_channel_dma_sequencer.sv ***
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module four_channel_dma_sequencer
   import dma_seq_pkg::*;
#(
   parameter int CNT_W  = 24,
   parameter int DATA_W = 128
) (
   // clock and reset
   input  wire logic               core_clk_i,
   input  wire logic               rst_i,
   // register port
   input  wire logic [REG_A_W-1:0] reg_addr_i,
   input  wire logic [REG_D_W-1:0] reg_wdata_i,
   input  wire logic               reg_wr_i,
   input  wire logic               reg_rd_i,
   output logic [REG_D_W-1:0]      reg_rdata_o,
   // external request pins
   input  wire logic [NCH-1:0]     dma_request_pin_i,
   // internal bus master
   output logic                    bus_req_o,
   input  wire logic               bus_gnt_i,
   output var bus_cmd_type         bus_cmd_o,
   output logic [DATA_W-1:0]       bus_wdata_o,
   input  wire logic [DATA_W-1:0]  bus_rdata_i,
   input  wire logic               bus_ack_i,
   input  wire logic               bus_err_i,
   // interrupt
   output logic                    irq_o
);

   typedef enum logic [2:0] {
      S_IDLE,
      S_SETUP,
      S_READ,
      S_WRITE,
      S_GAP
   } state_type;

   function automatic logic [4:0] width_bytes(input logic [1:0] code);
      case (code)
         SZ_LONG: width_bytes = BYTES_LONG;
         SZ_BYTE: width_bytes = BYTES_BYTE;
         SZ_WORD: width_bytes = BYTES_WORD;
         default: width_bytes = BYTES_LINE;
      endcase
   endfunction

   function automatic logic misal(input logic [ADDR_W-1:0] a,
                                  input logic [4:0]        w);
      misal = (a & ADDR_W'(w - BYTES_BYTE)) != '0;
   endfunction

   // largest access the address, width and bytes left allow
   function automatic logic [4:0] fit(input logic [ADDR_W-1:0] a,
                                      input logic [4:0]        maxb,
                                      input logic [CNT_W-1:0]  rem);
      if (maxb >= BYTES_LINE && !misal(a, BYTES_LINE)
          && rem >= CNT_W'(BYTES_LINE)) begin
         fit = BYTES_LINE;
      end else if (maxb >= BYTES_LONG && !misal(a, BYTES_LONG)
                   && rem >= CNT_W'(BYTES_LONG)) begin
         fit = BYTES_LONG;
      end else if (maxb >= BYTES_WORD && !misal(a, BYTES_WORD)
                   && rem >= CNT_W'(BYTES_WORD)) begin
         fit = BYTES_WORD;
      end else begin
         fit = BYTES_BYTE;
      end
   endfunction

   // z[n]: channel n outranks channel n-1
   function automatic logic [CH_W-1:0] pick(input logic [NCH-1:0] p,
                                            input logic [NCH-1:0] z);
      logic [CH_W-1:0] w;
      logic            found;
      int              c;
      w = '0;
      found = 1'b0;
      for (int s = 0; s < NCH; s++) begin
         c = s;
         if (s + 1 < NCH && z[s+1]) begin
            c = s + 1;
         end else if (s > 0 && z[s]) begin
            c = s - 1;
         end
         if (!found && p[c]) begin
            w = CH_W'(c);
            found = 1'b1;
         end
      end
      pick = w;
   endfunction

   ctrl_type          ctrl_r [NCH];
   logic [ADDR_W-1:0] src_r  [NCH];
   logic [ADDR_W-1:0] dst_r  [NCH];
   logic [CNT_W-1:0]  cnt_r  [NCH];
   logic [REG_D_W-1:0] stat_w [NCH];
   logic [NCH-1:0]    done_r;
   logic [NCH-1:0]    busy_r;
   logic [NCH-1:0]    bes_r;
   logic [NCH-1:0]    bed_r;
   logic [NCH-1:0]    ce_r;
   logic [NCH-1:0]    act_r;
   logic [NCH-1:0]    clr_w;
   logic [NCH-1:0]    z_w;
   logic [NCH-1:0]    pend_w;
   logic [NCH-1:0]    ien_w;
   logic [NCH-1:0]    cur_oh;

   state_type         state_r;
   logic [CH_W-1:0]   cur_r;
   logic [4:0]        xfer_r;
   logic [4:0]        off_r;
   logic              abort_r;
   logic [DATA_W-1:0] hold_r;
   bus_cmd_type       cmd_r;
   logic [DATA_W-1:0] wdata_r;
   logic              req_r;
   logic              irq_r;
   logic [REG_D_W-1:0] rdata_r;

   logic [CH_W-1:0]   ch_a;
   logic [IDX_W-1:0]  idx_a;
   logic              hit;
   ctrl_type          cc;
   logic [ADDR_W-1:0] sa;
   logic [ADDR_W-1:0] da;
   logic [CNT_W-1:0]  cn;
   logic [CNT_W-1:0]  cnt_new;
   logic [CNT_W-1:0]  blk;
   logic [4:0]        sw;
   logic [4:0]        dw;
   logic [4:0]        xfer_c;
   logic [4:0]        left;
   logic [4:0]        rd_beat;
   logic [4:0]        wr_beat;
   logic              src_al;
   logic              ce_c;
   logic              src_inc;
   logic              dst_inc;
   logic              boundary;
   logic              clr_cur;
   logic              rd_ok;
   logic              rd_err;
   logic              rd_good;
   logic              wr_ok;
   logic              wr_err;
   logic              wr_good;
   logic              seg_end;
   logic              last_wr;
   logic              setup;
   logic              sel_w;
   logic              set_ce;
   logic              set_done;

   // register address decode
   assign ch_a  = reg_addr_i[CH_LSB +: CH_W];
   assign idx_a = reg_addr_i[IDX_LSB +: IDX_W];
   assign hit   = reg_addr_i[REG_A_W-1:TOP_LSB] == '0;

   // current channel view, live so control writes act at once
   assign cc      = ctrl_r[cur_r];
   assign sa      = src_r[cur_r];
   assign da      = dst_r[cur_r];
   assign cn      = cnt_r[cur_r];
   assign sw      = width_bytes(cc.source_width);
   assign dw      = width_bytes(cc.destination_width);
   assign src_al  = sw >= dw;
   assign src_inc = cc.source_step_enable | (cc.auto_align & src_al);
   assign dst_inc = cc.dest_step_enable | (cc.auto_align & ~src_al);
   assign clr_cur = |(clr_w & cur_oh);

   // transfer size and configuration check
   always_comb begin
      if (cc.auto_align) begin
         xfer_c = src_al ? fit(sa, sw, cn) : fit(da, dw, cn);
         ce_c   = src_al ? misal(da, dw) : misal(sa, sw);
      end else begin
         xfer_c = src_al ? sw : dw;
         ce_c   = misal(sa, sw) | misal(da, dw)
                  | ((cn & CNT_W'(xfer_c - BYTES_BYTE)) != '0);
      end
   end

   // beat sizes, bounded by bytes left in this transfer
   assign left    = xfer_r - off_r;
   assign rd_beat = fit(sa, sw, CNT_W'(left));
   assign wr_beat = fit(da, dw, CNT_W'(left));

   // bandwidth block boundary; an unaligned jump past it never matches
   assign cnt_new  = cn - CNT_W'(xfer_r);
   assign blk      = CNT_W'(BW_UNIT) << (cc.bandwidth_limit - BW_STEP);
   assign boundary = (cc.bandwidth_limit != BW_NONE)
                     && ((cnt_new & (blk - CNT_W'(BYTES_BYTE))) == '0);

   // engine events
   assign rd_ok    = (state_r == S_READ) & cmd_r.cyc & bus_ack_i & ~abort_r;
   assign rd_err   = rd_ok & bus_err_i;
   assign rd_good  = rd_ok & ~bus_err_i;
   assign wr_ok    = (state_r == S_WRITE) & cmd_r.cyc & bus_ack_i & ~abort_r;
   assign wr_err   = wr_ok & bus_err_i;
   assign wr_good  = wr_ok & ~bus_err_i;
   assign seg_end  = (off_r + cmd_r.size) >= xfer_r;
   assign last_wr  = wr_good & seg_end;
   assign setup    = (state_r == S_SETUP) & ~abort_r & ~clr_cur;
   assign sel_w    = setup & ~ce_c & (cn != '0);
   assign set_ce   = setup & ce_c & (cn != '0);
   assign set_done = rd_err | wr_err | (setup & ~sel_w)
                     | (last_wr & (cnt_new == '0));

   for (genvar n = 0; n < NCH; n++) begin : g_ch
      logic wsel;
      logic mine;
      assign wsel      = reg_wr_i & hit & (ch_a == CH_W'(n));
      assign cur_oh[n] = cur_r == CH_W'(n);
      assign mine      = cur_oh[n] & (state_r != S_IDLE);
      assign clr_w[n]  = wsel & (idx_a == REG_STAT) & reg_wdata_i[ST_DONE];
      assign ien_w[n]  = ctrl_r[n].irq_enable & done_r[n];
      assign pend_w[n] = ~done_r[n] & (ctrl_r[n].start | act_r[n]
                         | (ctrl_r[n].external_request_enable
                            & dma_request_pin_i[n]));

      if (n == 0) begin : g_first
         assign z_w[n] = 1'b0;
      end else begin : g_rest
         assign z_w[n] = (ctrl_r[n].bandwidth_limit == BW_NONE)
                         & (ctrl_r[n-1].bandwidth_limit != BW_NONE);
      end

      always_comb begin
         stat_w[n]          = '0;
         stat_w[n][ST_DONE] = done_r[n];
         stat_w[n][ST_BUSY] = busy_r[n];
         stat_w[n][ST_REQ]  = pend_w[n] & ~mine;
         stat_w[n][ST_BED]  = bed_r[n];
         stat_w[n][ST_BES]  = bes_r[n];
         stat_w[n][ST_CE]   = ce_r[n];
      end

      // control word
      always_ff @(posedge core_clk_i or posedge rst_i) begin
         if (rst_i) begin
            ctrl_r[n] <= CTRL_RST;
         end else if (wsel && idx_a == REG_CTRL) begin
            ctrl_r[n] <= ctrl_type'(reg_wdata_i);
         end else if (sel_w && cur_oh[n]) begin
            ctrl_r[n].start <= 1'b0;
         end
      end

      // addresses and byte count
      always_ff @(posedge core_clk_i or posedge rst_i) begin
         if (rst_i) begin
            src_r[n] <= '0;
            dst_r[n] <= '0;
            cnt_r[n] <= '0;
         end else begin
            if (wsel && idx_a == REG_SRC) begin
               src_r[n] <= reg_wdata_i;
            end else if (rd_good && cur_oh[n] && src_inc) begin
               src_r[n] <= src_r[n] + ADDR_W'(cmd_r.size);
            end
            if (wsel && idx_a == REG_DST) begin
               dst_r[n] <= reg_wdata_i;
            end else if (wr_good && cur_oh[n] && dst_inc) begin
               dst_r[n] <= dst_r[n] + ADDR_W'(cmd_r.size);
            end
            if (wsel && idx_a == REG_CNT) begin
               cnt_r[n] <= reg_wdata_i[CNT_W-1:0];
            end else if (last_wr && cur_oh[n]) begin
               cnt_r[n] <= cnt_new;
            end
         end
      end

      // status flags, hardware set wins over clear
      always_ff @(posedge core_clk_i or posedge rst_i) begin
         if (rst_i) begin
            done_r[n] <= 1'b0;
            busy_r[n] <= 1'b0;
            bes_r[n]  <= 1'b0;
            bed_r[n]  <= 1'b0;
            ce_r[n]   <= 1'b0;
            act_r[n]  <= 1'b0;
         end else begin
            done_r[n] <= (set_done & cur_oh[n])
                         | (done_r[n] & ~clr_w[n]);
            bes_r[n]  <= (rd_err & cur_oh[n]) | (bes_r[n] & ~clr_w[n]);
            bed_r[n]  <= (wr_err & cur_oh[n]) | (bed_r[n] & ~clr_w[n]);
            ce_r[n]   <= (set_ce & cur_oh[n]) | (ce_r[n] & ~clr_w[n]);
            busy_r[n] <= (sel_w & cur_oh[n]) | (busy_r[n] & ~clr_w[n]
                         & ~(set_done & cur_oh[n]));
            act_r[n]  <= (sel_w & cur_oh[n] & ~ctrl_r[n].cycle_steal_sel)
                         | (act_r[n] & ~clr_w[n] & ~(set_done & cur_oh[n])
                            & ~(last_wr & cur_oh[n]
                                & ctrl_r[n].cycle_steal_sel));
         end
      end
   end

   // abort request from a done write on the serving channel
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         abort_r <= 1'b0;
      end else if (state_r == S_IDLE) begin
         abort_r <= 1'b0;
      end else if (clr_cur) begin
         abort_r <= 1'b1;
      end
   end

   // sequencer
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= S_IDLE;
         cur_r   <= '0;
         xfer_r  <= '0;
         off_r   <= '0;
      end else begin
         case (state_r)
            S_IDLE: begin
               if (|(pend_w & ~clr_w)) begin
                  cur_r   <= pick(pend_w & ~clr_w, z_w);
                  state_r <= S_SETUP;
               end
            end
            S_SETUP: begin
               xfer_r  <= xfer_c;
               off_r   <= '0;
               state_r <= sel_w ? S_READ : S_IDLE;
            end
            S_READ: begin
               if (abort_r && !cmd_r.cyc) begin
                  state_r <= S_IDLE;
               end else if (rd_err) begin
                  state_r <= S_IDLE;
               end else if (rd_good && seg_end) begin
                  off_r   <= '0;
                  state_r <= S_WRITE;
               end else if (rd_good) begin
                  off_r <= off_r + cmd_r.size;
               end
            end
            S_WRITE: begin
               if (abort_r && !cmd_r.cyc) begin
                  state_r <= S_IDLE;
               end else if (wr_err) begin
                  state_r <= S_IDLE;
               end else if (last_wr) begin
                  off_r <= '0;
                  if (cnt_new != '0 && !cc.cycle_steal_sel && boundary) begin
                     state_r <= S_GAP;
                  end else begin
                     state_r <= S_IDLE;
                  end
               end else if (wr_good) begin
                  off_r <= off_r + cmd_r.size;
               end
            end
            S_GAP: begin
               state_r <= S_IDLE;
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

   // bus cycles, issued only under grant
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cmd_r   <= CMD_RST;
         wdata_r <= '0;
      end else if (cmd_r.cyc) begin
         if (bus_ack_i) begin
            cmd_r.cyc <= 1'b0;
         end
      end else if (!abort_r && bus_gnt_i && state_r == S_READ) begin
         cmd_r <= '{cyc: 1'b1, we: 1'b0, size: rd_beat, addr: sa};
      end else if (!abort_r && bus_gnt_i && state_r == S_WRITE) begin
         cmd_r   <= '{cyc: 1'b1, we: 1'b1, size: wr_beat, addr: da};
         wdata_r <= hold_r >> (off_r * BYTE_BITS);
      end
   end

   // holding register
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         hold_r <= '0;
      end else if (state_r == S_SETUP || wr_err) begin
         hold_r <= '0;
      end else if (rd_good) begin
         hold_r <= hold_r | ((bus_rdata_i
                   & ((DATA_W'(1) << (cmd_r.size * BYTE_BITS)) - DATA_W'(1)))
                   << (off_r * BYTE_BITS));
      end
   end

   // bus request, low for one cycle after a block boundary
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         req_r <= 1'b0;
      end else begin
         req_r <= (state_r != S_GAP)
                  && ((state_r != S_IDLE) || (|pend_w));
      end
   end

   // interrupt line
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |ien_w;
      end
   end

   // register read, data valid one cycle after the strobe only
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_r <= '0;
      end else if (reg_rd_i && hit) begin
         case (idx_a)
            REG_CTRL: rdata_r <= REG_D_W'(ctrl_r[ch_a]);
            REG_SRC:  rdata_r <= src_r[ch_a];
            REG_DST:  rdata_r <= dst_r[ch_a];
            REG_CNT:  rdata_r <= REG_D_W'(cnt_r[ch_a]);
            REG_STAT: rdata_r <= stat_w[ch_a];
            default:  rdata_r <= '0;
         endcase
      end else begin
         rdata_r <= '0;
      end
   end
   assign reg_rdata_o = rdata_r;
   assign bus_req_o   = req_r;
   assign bus_cmd_o   = cmd_r;
   assign bus_wdata_o = wdata_r;
   assign irq_o       = irq_r;

endmodule
`default_nettype wire

// *** rtl/dma_seq_pkg.sv ***
package dma_seq_pkg;
   localparam int NCH       = 4;
   localparam int CH_W      = 2;
   localparam int ADDR_W    = 32;
   localparam int REG_A_W   = 8;
   localparam int REG_D_W   = 32;
   localparam int IDX_W     = 3;
   localparam int IDX_LSB   = 2;
   localparam int CH_LSB    = 5;
   localparam int TOP_LSB   = CH_LSB + CH_W;
   localparam int BYTE_BITS = 8;
   localparam int BW_UNIT   = 16;

   localparam logic [IDX_W-1:0] REG_CTRL = 3'h0;
   localparam logic [IDX_W-1:0] REG_SRC  = 3'h1;
   localparam logic [IDX_W-1:0] REG_DST  = 3'h2;
   localparam logic [IDX_W-1:0] REG_CNT  = 3'h3;
   localparam logic [IDX_W-1:0] REG_STAT = 3'h4;

   localparam int ST_DONE = 0;
   localparam int ST_BUSY = 1;
   localparam int ST_REQ  = 2;
   localparam int ST_BED  = 4;
   localparam int ST_BES  = 5;
   localparam int ST_CE   = 6;

   localparam logic [1:0] SZ_LONG = 2'h0;
   localparam logic [1:0] SZ_BYTE = 2'h1;
   localparam logic [1:0] SZ_WORD = 2'h2;

   localparam logic [4:0] BYTES_BYTE = 5'h01;
   localparam logic [4:0] BYTES_WORD = 5'h02;
   localparam logic [4:0] BYTES_LONG = 5'h04;
   localparam logic [4:0] BYTES_LINE = 5'h10;

   localparam logic [2:0] BW_NONE = 3'h0;
   localparam logic [2:0] BW_STEP = 3'h1;

   typedef struct packed {
      logic [16:0] reserved;
      logic [2:0]  bandwidth_limit;
      logic [1:0]  destination_width;
      logic [1:0]  source_width;
      logic        spare;
      logic        dest_step_enable;
      logic        source_step_enable;
      logic        irq_enable;
      logic        auto_align;
      logic        cycle_steal_sel;
      logic        external_request_enable;
      logic        start;
   } ctrl_type;

   typedef struct packed {
      logic              cyc;
      logic              we;
      logic [4:0]        size;
      logic [ADDR_W-1:0] addr;
   } bus_cmd_type;

   localparam ctrl_type    CTRL_RST = '0;
   localparam bus_cmd_type CMD_RST  = '0;
endpackage

// *** tb/dma_seq_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module dma_seq_props
   import dma_seq_pkg::*;
(
   // clock and reset
   input  wire logic               core_clk_i,
   input  wire logic               rst_i,
   // register port
   input  wire logic               reg_rd_i,
   input  wire logic [REG_D_W-1:0] reg_rdata_o,
   // bus side
   input  wire logic               bus_req_o,
   input  wire logic               bus_gnt_i,
   input  wire bus_cmd_type        bus_cmd_o,
   input  wire logic               bus_ack_i,
   input  wire logic               bus_err_i
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_beat_wait;
      bus_cmd_o.cyc && !bus_ack_i;
   endsequence
   sequence s_beat_end;
      bus_cmd_o.cyc && bus_ack_i;
   endsequence
   a_grant_gates: assert property ($rose(bus_cmd_o.cyc) |-> $past(bus_gnt_i))
      else $error("bus cycle began without grant");
   a_request_up: assert property ($rose(bus_cmd_o.cyc) |-> bus_req_o)
      else $error("bus cycle began without request");
   a_beat_holds: assert property (s_beat_wait |=> bus_cmd_o.cyc && $stable(bus_cmd_o))
      else $error("bus command changed before ack");
   a_beat_ends: assert property (s_beat_end |=> !bus_cmd_o.cyc)
      else $error("bus cycle held after ack");
   a_error_halts: assert property (s_beat_end ##0 bus_err_i |=> !bus_cmd_o.cyc [*2])
      else $error("bus activity right after error");
   a_size_legal: assert property (bus_cmd_o.cyc |-> bus_cmd_o.size inside {5'h01, 5'h02, 5'h04, 5'h10})
      else $error("illegal access size");
   a_addr_aligned: assert property (bus_cmd_o.cyc |-> (bus_cmd_o.addr[4:0] & (bus_cmd_o.size - 5'h01)) == 5'h00)
      else $error("access not aligned to its size");
   a_rdata_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
      else $error("read data outside read slot");
   cover property (s_beat_end ##0 bus_err_i);
endmodule
`default_nettype wire

// *** tb/bus_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bus_mem_model
   import dma_seq_pkg::*;
#(
   parameter int DATA_W = 128
) (
   // clock and reset
   input  wire logic              core_clk_i,
   input  wire logic              rst_i,
   // bench controls
   input  wire logic              gnt_en_i,
   input  wire logic [3:0]        lat_i,
   input  wire logic [1:0]        err_sel_i,
   // bus
   input  wire logic              bus_req_i,
   output logic                   bus_gnt_o,
   input  wire bus_cmd_type       bus_cmd_i,
   input  wire logic [DATA_W-1:0] bus_wdata_i,
   output logic [DATA_W-1:0]      bus_rdata_o,
   output logic                   bus_ack_o,
   output logic                   bus_err_o
);
   logic [7:0] mem [0:255];
   logic [3:0] wait_r;
   logic       hit;
   logic       bad;
   assign bus_gnt_o = gnt_en_i && bus_req_i;
   assign hit = bus_cmd_i.cyc && !bus_ack_o && wait_r == lat_i;
   assign bad = err_sel_i[bus_cmd_i.we];
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'hA5;
      end
   end
   // ack after a bench-set delay, optional error
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_r      <= 4'h0;
         bus_ack_o   <= 1'b0;
         bus_err_o   <= 1'b0;
         bus_rdata_o <= '0;
      end else begin
         bus_ack_o   <= hit;
         bus_err_o   <= hit && bad;
         wait_r      <= (bus_cmd_i.cyc && !hit && !bus_ack_o) ? wait_r + 4'h1 : 4'h0;
         bus_rdata_o <= ~bus_rdata_o;
         for (int b = 0; b < 16; b++) begin
            if (hit && b < int'(bus_cmd_i.size)) begin
               if (!bus_cmd_i.we) begin
                  bus_rdata_o[8*b+:8] <= mem[8'(bus_cmd_i.addr) + 8'(b)];
               end else if (!bad) begin
                  mem[8'(bus_cmd_i.addr) + 8'(b)] <= bus_wdata_i[8*b+:8];
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/test_four_channel_dma_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module test_four_channel_dma_sequencer;
   import dma_seq_pkg::*;
   logic               core_clk_i;
   logic               rst_i;
   logic [7:0]         reg_addr_i;
   logic [31:0]        reg_wdata_i;
   logic               reg_wr_i;
   logic               reg_rd_i;
   logic [31:0]        reg_rdata_o;
   logic [3:0]         dma_request_pin_i;
   logic               bus_req_o;
   logic               bus_gnt_i;
   bus_cmd_type        bus_cmd_o;
   logic [127:0]       bus_wdata_o;
   logic [127:0]       bus_rdata_i;
   logic               bus_ack_i;
   logic               bus_err_i;
   logic               irq_o;
   logic               gnt_en;
   logic [3:0]         lat;
   logic [1:0]         err_sel;
   logic               req_q;
   logic               armed;
   logic [31:0]        first_addr;
   logic [4:0]         n_rd;
   logic [12:0]        rdq [$];
   logic [31:0]        v;
   int                 n_fail;
   int                 n_checks;
   int                 n_drop;
   int                 plo [4] = '{0, 1, 1, 2};
   logic [2:0]         pbl [4] = '{3'h0, 3'h1, 3'h1, 3'h2};
   logic [2:0]         pbh [4] = '{3'h0, 3'h1, 3'h0, 3'h3};
   int                 pex [4] = '{0, 1, 2, 2};
   logic [4:0]         beats [4] = '{5'h04, 5'h10, 5'h08, 5'h01};
   four_channel_dma_sequencer four_channel_dma_sequencer_i (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .dma_request_pin_i(dma_request_pin_i),
      .bus_req_o(bus_req_o), .bus_gnt_i(bus_gnt_i), .bus_cmd_o(bus_cmd_o),
      .bus_wdata_o(bus_wdata_o), .bus_rdata_i(bus_rdata_i),
      .bus_ack_i(bus_ack_i), .bus_err_i(bus_err_i), .irq_o(irq_o));
   bus_mem_model bus_mem_model_i (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .gnt_en_i(gnt_en),
      .lat_i(lat), .err_sel_i(err_sel), .bus_req_i(bus_req_o),
      .bus_gnt_o(bus_gnt_i), .bus_cmd_i(bus_cmd_o),
      .bus_wdata_i(bus_wdata_o), .bus_rdata_o(bus_rdata_i),
      .bus_ack_o(bus_ack_i), .bus_err_o(bus_err_i));
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   // bus watch: request drops, first address, read beats
   always @(posedge core_clk_i) begin
      req_q <= bus_req_o;
      if (req_q && !bus_req_o) n_drop <= n_drop + 1;
      if (armed && bus_cmd_o.cyc) begin
         first_addr <= bus_cmd_o.addr;
         armed      <= 1'b0;
      end
      if (bus_cmd_o.cyc && bus_ack_i && !bus_cmd_o.we) begin
         n_rd <= n_rd + 5'h01;
         rdq.push_back({bus_cmd_o.addr[7:0], bus_cmd_o.size});
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic wr(input int ch, input logic [2:0] idx, input logic [31:0] d);
      reg_addr_i  <= 8'((ch << 5) | (int'(idx) << 2));
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i    <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task automatic rd(input int ch, input logic [2:0] idx, output logic [31:0] d);
      reg_addr_i <= 8'((ch << 5) | (int'(idx) << 2));
      reg_rd_i   <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i   <= 1'b0;
      #1 d = reg_rdata_o;
      @(posedge core_clk_i);
   endtask
   task automatic chkr(input int ch, input logic [2:0] idx, input logic [31:0] e);
      logic [31:0] r;
      rd(ch, idx, r);
      `CHK(r, e)
   endtask
   task automatic chkm(input int d, input int s, input int n);
      for (int i = 0; i < n; i++) `CHK(bus_mem_model_i.mem[8'(d + i)], 8'(s + i) ^ 8'hA5)
   endtask
   function automatic logic [31:0] mk(input logic [6:0] f, input int sw, input int dw,
                                      input logic [2:0] bw);
      return {17'h0, bw, 2'(dw), 2'(sw), 1'b0, f};
   endfunction
   task automatic prog(input int ch, input int s, input int d, input int c,
                       input logic [31:0] ctl);
      wr(ch, REG_STAT, 32'h1);
      wr(ch, REG_SRC, 32'(s));
      wr(ch, REG_DST, 32'(d));
      wr(ch, REG_CNT, 32'(c));
      wr(ch, REG_CTRL, ctl);
   endtask
   task automatic wait_done(input int ch);
      logic [31:0] st;
      for (int k = 0; k < 300; k++) begin
         rd(ch, REG_STAT, st);
         if (st[ST_DONE] === 1'b1) return;
      end
      `CHK(st[ST_DONE], 1'b1)
   endtask
   initial begin
      #400000;
      n_fail++;
      summarize();
   end
   initial begin
      {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, dma_request_pin_i} = '0;
      {lat, err_sel, armed, req_q, n_rd, n_drop} = '0;
      gnt_en = 1'b1;
      rst_i = 1'b1;
      repeat (2) @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(posedge core_clk_i);
      for (int w = 0; w < 4; w++) begin
         n_rd = 5'h00;
         prog(0, 0, 128 + w * 16, 16, mk(7'h61, w, w, 3'h0));
         wait_done(0);
         `CHK(n_rd, beats[w])
         chkr(0, REG_SRC, 32'h10);
         chkr(0, REG_DST, 32'(144 + w * 16));
         chkr(0, REG_CNT, 32'h0);
         chkr(0, REG_CTRL, mk(7'h60, w, w, 3'h0));
         chkm(128 + w * 16, 0, 16);
      end
      prog(1, 32, 192, 4, mk(7'h41, 1, 1, 3'h0));
      wait_done(1);
      chkr(1, REG_SRC, 32'h20);
      `CHK(bus_mem_model_i.mem[195], 8'h20 ^ 8'hA5)
      for (int e = 0; e < 2; e++) begin
         err_sel <= 2'(1 << e);
         prog(2, 0, 208, 4, mk(7'h71, 0, 0, 3'h0));
         wait_done(2);
         err_sel <= 2'h0;
         chkr(2, REG_STAT, e ? 32'h11 : 32'h21);
         `CHK(bus_mem_model_i.mem[208], 8'hD0 ^ 8'hA5)
         `CHK(irq_o, 1'b1)
         wr(2, REG_STAT, 32'h1);
         chkr(2, REG_STAT, 32'h0);
         `CHK(irq_o, 1'b0)
      end
      for (int p = 0; p < 4; p++) begin
         prog(plo[p], plo[p] * 16, 224, 4, mk(7'h62, 0, 0, pbl[p]));
         prog(plo[p] + 1, plo[p] * 16 + 16, 232, 4, mk(7'h62, 0, 0, pbh[p]));
         armed = 1'b1;
         dma_request_pin_i <= 4'(3 << plo[p]);
         wait_done(plo[p]);
         wait_done(plo[p] + 1);
         dma_request_pin_i <= 4'h0;
         `CHK(first_addr, 32'(pex[p] * 16))
      end
      for (int b = 0; b < 2; b++) begin
         prog(3, 0, 64, 32, mk(7'h61, 0, 0, 3'(b)));
         n_drop = 0;
         wait_done(3);
         repeat (3) @(posedge core_clk_i);
         `CHK(n_drop, b + 1)
      end
      prog(1, 0, 176, 8, mk(7'h65, 0, 0, 3'h0));
      repeat (30) @(posedge core_clk_i);
      chkr(1, REG_CNT, 32'h4);
      wr(1, REG_CTRL, mk(7'h65, 0, 0, 3'h0));
      wait_done(1);
      chkr(1, REG_CNT, 32'h0);
      rdq.delete();
      prog(2, 1, 96, 7, mk(7'h69, 0, 1, 3'h0));
      wait_done(2);
      `CHK({rdq[0], rdq[1], rdq[2]}, {13'h0021, 13'h0042, 13'h0084})
      chkr(2, REG_SRC, 32'h8);
      chkr(2, REG_DST, 32'h67);
      chkm(96, 1, 7);
      lat <= 4'hF;
      gnt_en <= 1'b0;
      prog(0, 0, 160, 64, mk(7'h61, 0, 0, 3'h0));
      repeat (20) @(posedge core_clk_i);
      `CHK(bus_cmd_o.cyc, 1'b0)
      gnt_en <= 1'b1;
      repeat (60) @(posedge core_clk_i);
      wr(0, REG_STAT, 32'h1);
      repeat (40) @(posedge core_clk_i);
      chkr(0, REG_STAT, 32'h0);
      rd(0, REG_CNT, v);
      `CHK(v != 32'h0, 1'b1)
      `CHK(bus_cmd_o.cyc, 1'b0)
      summarize();
   end
endmodule
bind four_channel_dma_sequencer dma_seq_props dma_seq_props_i (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .bus_req_o(bus_req_o), .bus_gnt_i(bus_gnt_i),
   .bus_cmd_o(bus_cmd_o), .bus_ack_i(bus_ack_i), .bus_err_i(bus_err_i));
`default_nettype wire
